/* hdl/eeprom_status_pkg.sv */
// constants for the serial eeprom status-write block
package eeprom_status_pkg;
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] CMD_STATUS_READ = 8'h05;
	localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
	localparam int BIT_STATUS_WRITE_DISABLE_POS = 7;
	localparam int BIT_PSEL_HI = 3;
	localparam int BIT_PSEL_LO = 2;
	localparam int BIT_WEL_POS = 1;
	localparam int BIT_WIP_POS = 0;
	localparam logic [3:0] RSV_SMALL = 4'hF;
	localparam logic [2:0] RSV_LARGE = 3'h0;
	localparam logic [1:0] PROT_NONE = 2'h0;
	localparam logic [1:0] PROT_QUARTER = 2'h1;
	localparam logic [1:0] PROT_HALF = 2'h2;
	localparam logic [1:0] PROT_ALL = 2'h3;
	localparam int SMALL_KBIT = 4;
	localparam int BYTE_BITS = 8;
	localparam int WRITE_TIME_US = 5;
	localparam int CLK_MHZ = 10;
	localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
endpackage

/* hdl/eeprom_status_write.sv */
// status register and command decoder of an spi serial eeprom slave
// ---------------------------------------------------------------
// Behaviour
// - status write carries exactly one data byte
// - bits 3..2 select protected array region
// - bits 1..0 read only, not loaded from the data byte
// - large parts: bit 7 set blocks status writes
// - bit 0 reads one during nonvolatile write
// ---------------------------------------------------------------
`timescale 1ns/1ps
module eeprom_status_write
	import eeprom_status_pkg::*;
#(
	parameter int SIZE_KBIT = 64,
	parameter int BUSY_CYCLES = WRITE_CYCLES
) (
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_sck,
	input  wire logic       i_cs_n,
	input  wire logic       i_mosi,
	output logic            o_miso,
	output logic            o_miso_oe,
	output logic [1:0]      o_protect_region,
	output logic [7:0]      o_status
);
	localparam bit LARGE = SIZE_KBIT > SMALL_KBIT;
	// busy counter is 16 bits wide and must load a nonzero count
	if (SIZE_KBIT < 1 || BUSY_CYCLES < 1 || BUSY_CYCLES > 65535) begin : g_bad_param
		$error("eeprom_status_write: bad parameter");
	end

	// ---------------------------------------------------------------
	// pin synchronisers and edge detection
	// ---------------------------------------------------------------
	logic [1:0] sck_s, cs_s, mosi_s;
	logic       sck_d, cs_d;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sck_s  <= 2'h0;
			cs_s   <= 2'h3;
			mosi_s <= 2'h0;
			sck_d  <= 1'b0;
			cs_d   <= 1'b1;
		end else begin
			sck_s  <= {sck_s[0], i_sck};
			cs_s   <= {cs_s[0], i_cs_n};
			mosi_s <= {mosi_s[0], i_mosi};
			sck_d  <= sck_s[1];
			cs_d   <= cs_s[1];
		end
	end
	wire sck_rise = sck_s[1] & ~sck_d;
	wire sck_fall = ~sck_s[1] & sck_d;
	wire cs_active = ~cs_s[1];
	wire cs_release = cs_s[1] & ~cs_d;

	// ---------------------------------------------------------------
	// shift register and byte counter
	// ---------------------------------------------------------------
	logic [7:0] shift;
	logic [2:0] bit_cnt;
	logic [1:0] byte_cnt;
	logic [7:0] cmd;
	logic [7:0] data;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			shift    <= 8'h00;
			bit_cnt  <= 3'h0;
			byte_cnt <= 2'h0;
			cmd      <= 8'h00;
			data     <= 8'h00;
		end else if (!cs_active) begin
			bit_cnt  <= 3'h0;
			byte_cnt <= 2'h0;
		end else if (sck_rise) begin
			shift   <= {shift[6:0], mosi_s[1]};
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'(BYTE_BITS - 1)) begin
				if (byte_cnt == 2'h0)
					cmd <= {shift[6:0], mosi_s[1]};
				else if (byte_cnt == 2'h1)
					data <= {shift[6:0], mosi_s[1]};
				if (byte_cnt != 2'h3)
					byte_cnt <= byte_cnt + 2'h1;
			end
		end
	end
	// a frame is complete only on a whole byte boundary
	wire aligned = (bit_cnt == 3'h0);
	wire one_cmd = aligned && byte_cnt == 2'h1;
	wire cmd_plus_byte = aligned && byte_cnt == 2'h2;

	// ---------------------------------------------------------------
	// status state
	// ---------------------------------------------------------------
	logic        status_write_disable;
	logic [1:0]  prot;
	logic        write_enable_latch;
	logic [15:0] busy_cnt;
	wire         write_in_progress = (busy_cnt != 16'h0);
	wire is_wsr = cmd_plus_byte && cmd == CMD_STATUS_WRITE;
	// write disable flag blocks the protect field and itself; the write enable latch still clears
	wire wsr_ok = is_wsr && write_enable_latch && !write_in_progress && !(LARGE && status_write_disable);
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			status_write_disable <= 1'b0;
			prot <= PROT_NONE;
		end else if (cs_release && wsr_ok) begin
			prot <= data[BIT_PSEL_HI:BIT_PSEL_LO];
			if (LARGE)
				status_write_disable <= data[BIT_STATUS_WRITE_DISABLE_POS];
		end
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			write_enable_latch <= 1'b0;
		end else if (cs_release && !write_in_progress) begin
			if (one_cmd && cmd == CMD_WRITE_ENABLE)
				write_enable_latch <= 1'b1;
			else if (one_cmd && cmd == CMD_WRITE_DISABLE)
				write_enable_latch <= 1'b0;
			else if (is_wsr && write_enable_latch)
				write_enable_latch <= 1'b0;
		end
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			busy_cnt <= 16'h0;
		end else if (cs_release && wsr_ok) begin
			busy_cnt <= 16'(BUSY_CYCLES);
		end else if (write_in_progress) begin
			busy_cnt <= busy_cnt - 16'h1;
		end
	end

	logic [7:0] status_now;
	always_comb begin
		status_now = 8'h00;
		if (LARGE) begin
			status_now[BIT_STATUS_WRITE_DISABLE_POS] = status_write_disable;
			status_now[6:4] = RSV_LARGE;
		end else begin
			status_now[7:4] = RSV_SMALL;
		end
		status_now[BIT_PSEL_HI:BIT_PSEL_LO] = prot;
		status_now[BIT_WEL_POS] = write_enable_latch;
		status_now[BIT_WIP_POS] = write_in_progress;
	end

	// ---------------------------------------------------------------
	// read-back on miso, shifted out on falling sck
	// ---------------------------------------------------------------
	logic [7:0] out_sh;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			out_sh    <= 8'h00;
			o_miso    <= 1'b0;
			o_miso_oe <= 1'b0;
		end else if (!cs_active) begin
			o_miso_oe <= 1'b0;
			o_miso    <= 1'b0;
		end else if (sck_fall) begin
			if (byte_cnt != 2'h0 && aligned && cmd == CMD_STATUS_READ) begin
				o_miso    <= status_now[7];
				out_sh    <= {status_now[6:0], 1'b0};
				o_miso_oe <= 1'b1;
			end else if (o_miso_oe) begin
				o_miso <= out_sh[7];
				out_sh <= {out_sh[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_status         <= 8'h00;
			o_protect_region <= PROT_NONE;
		end else begin
			o_status         <= status_now;
			o_protect_region <= prot;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	sequence s_wsr_commit;
		cs_release && wsr_ok;
	endsequence
	property p_prot_load;
		@(posedge i_clk) disable iff (!i_arst_n)
		s_wsr_commit |=> prot == $past(data[3:2]);
	endproperty
	a_prot_load: assert property (p_prot_load)
		else $error("protect field not loaded");
	property p_prot_hold;
		@(posedge i_clk) disable iff (!i_arst_n)
		!(cs_release && wsr_ok) |=> $stable(prot);
	endproperty
	a_prot_hold: assert property (p_prot_hold)
		else $error("protect field changed without commit");
	property p_status_write_disable_block;
		@(posedge i_clk) disable iff (!i_arst_n)
		(LARGE && status_write_disable && cs_release && is_wsr) |=> $stable(prot);
	endproperty
	a_status_write_disable_block: assert property (p_status_write_disable_block)
		else $error("status changed while write disabled");
	property p_wel_needed;
		@(posedge i_clk) disable iff (!i_arst_n)
		(cs_release && is_wsr && !write_enable_latch) |=> $stable(prot) && $stable(status_write_disable);
	endproperty
	a_wel_needed: assert property (p_wel_needed)
		else $error("status written without write enable");
	property p_busy_start;
		@(posedge i_clk) disable iff (!i_arst_n)
		s_wsr_commit |=> write_in_progress ##1 o_status[0];
	endproperty
	a_busy_start: assert property (p_busy_start)
		else $error("busy bit not raised after status write");
	// cycles that the busy bit has stood high without a break
	logic [16:0] wip_run;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wip_run <= 17'h0;
		end else if (write_in_progress) begin
			wip_run <= wip_run + 17'h1;
		end else begin
			wip_run <= 17'h0;
		end
	end
	property p_busy_ends;
		@(posedge i_clk) disable iff (!i_arst_n)
		wip_run <= 17'(BUSY_CYCLES);
	endproperty
	a_busy_ends: assert property (p_busy_ends)
		else $error("busy never cleared");
	property p_no_partial;
		@(posedge i_clk) disable iff (!i_arst_n)
		(cs_release && cmd == CMD_STATUS_WRITE && !cmd_plus_byte)
			|=> $stable(prot);
	endproperty
	a_no_partial: assert property (p_no_partial)
		else $error("status written by malformed frame");
	property p_reserved;
		@(posedge i_clk) disable iff (!i_arst_n)
		$past(i_arst_n) |->
			(LARGE ? o_status[6:4] == RSV_LARGE : o_status[7:4] == RSV_SMALL);
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved status bits wrong");
endmodule

/* test/spi_host.sv */
// spi master model of the host driving the eeprom slave
`timescale 1ns/1ps
module spi_host
	import eeprom_status_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_miso,
	output logic      o_sck,
	output logic      o_cs_n,
	output logic      o_mosi
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end
	// each sck level lasts four clk cycles
	task automatic half();
		repeat (4) @(posedge i_clk);
		#1;
	endtask
	task automatic frame(input logic [23:0] d, input int nbits,
		output logic [7:0] rd);
		rd = 8'h00;
		o_cs_n = 1'b0;
		for (int i = nbits - 1; i >= 0; i--) begin
			o_mosi = d[i];
			half();
			o_sck = 1'b1;
			rd = {rd[6:0], i_miso};
			half();
			o_sck = 1'b0;
		end
		half();
		o_cs_n = 1'b1;
		// released data line shows the inverse of its last bit
		o_mosi = ~o_mosi;
		half();
	endtask
	// reserved bits come from the prior status read
	task automatic write_status(input logic [7:0] prior, input logic status_write_disable,
		input logic [1:0] p);
		logic [7:0] rd;
		frame({16'h0000, CMD_WRITE_ENABLE}, 8, rd);
		frame({8'h00, CMD_STATUS_WRITE, status_write_disable, prior[6:4], p, 2'b00},
			16, rd);
	endtask
endmodule

/* test/tb_eeprom_status_write.sv */
// self-checking bench for the eeprom status-write block
`timescale 1ns/1ps
module tb_eeprom_status_write;
	import eeprom_status_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_arst_n = 1'b0;
	logic        sck, cs_n, mosi, miso;
	logic [1:0]  prot, p;
	logic [7:0]  status, rd;
	logic        miso_oe;
	logic [7:0]  status_sm;
	int          oe_cycles = 0;
	logic [31:0] seed = 32'hE76E;
	int          error_cnt = 0;
	int          n_checks = 0;
	int          exp_st = 0;
	always #50 i_clk = ~i_clk;
	spi_host u_host (.i_clk(i_clk), .i_miso(miso), .o_sck(sck),
		.o_cs_n(cs_n), .o_mosi(mosi));
	eeprom_status_write #(.SIZE_KBIT(64), .BUSY_CYCLES(4)) u_dut (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sck(sck),
		.i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe),
		.o_protect_region(prot), .o_status(status));
	// small part on the same wires, to cover the small status layout
	eeprom_status_write #(.SIZE_KBIT(4), .BUSY_CYCLES(4)) u_small (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sck(sck),
		.i_cs_n(cs_n), .i_mosi(mosi), .o_miso(), .o_miso_oe(),
		.o_protect_region(), .o_status(status_sm));
	always @(posedge i_clk) begin
		if (miso_oe === 1'b1)
			oe_cycles++;
	end
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input int exp);
		n_checks++;
		if (got !== exp[7:0]) begin
			error_cnt++;
			$display("mismatch at %0t: %h %h", $time, got, exp[7:0]);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic wait_wip(input logic lvl);
		int n;
		n = 0;
		while (status[0] !== lvl && n < 30) begin
			tick(1);
			n++;
		end
		if (status[0] !== lvl) begin
			error_cnt++;
			$display("mismatch at %0t: %h %h", $time, status[0], lvl);
			report_and_stop();
		end
	endtask
	task automatic readback();
		int oe0;
		oe0 = oe_cycles;
		u_host.frame({8'h00, CMD_STATUS_READ, 8'h00}, 16, rd);
		check(rd, exp_st);
		check(status, exp_st);
		check({7'h00, oe_cycles > oe0}, 1);
		check({7'h00, miso_oe}, 0);
	endtask
	initial begin
		tick(20);
		i_arst_n = 1'b1;
		tick(3);
		check(status_sm, 8'hF0);
		readback();
		// status write without write enable is ignored
		u_host.frame({8'h00, CMD_STATUS_WRITE, 8'h0C}, 16, rd);
		tick(10);
		readback();
		for (int i = 0; i < 6; i++) begin
			seed = xorshift(seed);
			p = (i < 4) ? i[1:0] : seed[1:0];
			u_host.write_status(rd, 1'b0, p);
			wait_wip(1'b1);
			wait_wip(1'b0);
			exp_st = {p, 2'b00};
			check({6'h00, prot}, p);
			readback();
		end
		u_host.frame({16'h0000, CMD_WRITE_ENABLE}, 8, rd);
		tick(4);
		check(status, exp_st | 2);
		// one bit too many cancels the write
		u_host.frame({7'h00, CMD_STATUS_WRITE, 8'h00, 1'b0}, 17, rd);
		tick(10);
		check({6'h00, prot}, exp_st[3:2]);
		// write disable drops the latch again
		u_host.frame({16'h0000, CMD_WRITE_DISABLE}, 8, rd);
		tick(4);
		check(status, exp_st);
		u_host.write_status(rd, 1'b1, 2'b01);
		wait_wip(1'b1);
		wait_wip(1'b0);
		exp_st = 8'h84;
		readback();
		u_host.write_status(rd, 1'b0, 2'b11);
		tick(10);
		check({6'h00, prot}, 1);
		check({7'h00, status[7]}, 1);
		check(status_sm, 8'hFC);
		report_and_stop();
	end
endmodule
